// ==== pmu_regs.sv ====
// Linear regulator interrupt masking and step-down load current meter registers
`timescale 1ns/1ps
`include "pmu_regs_defs.svh"
`default_nettype none
module pmu_regs (
   // Clock and reset
   input  wire logic                     clk,
   input  wire logic                     rst_b,
   // Register access from the serial interface, same clock
   input  wire pmu_regs_pkg::reg_req_t   req,
   input  wire logic                     req_valid,
   output logic [7:0]                    rdata,
   // Live linear regulator conditions from analog pins
   input  wire pmu_regs_pkg::lin_state_t lin_a_pin,
   input  wire pmu_regs_pkg::lin_state_t lin_b_pin,
   // Load current converter interface
   input  wire logic [8:0]               meter_sample,
   output logic                          meter_sel_b,
   output logic                          meter_busy,
   // Interrupt request towards the host
   output logic                          irq
);
   import pmu_regs_pkg::*;

   localparam int METER_CYCLES = `METER_CYCLES;

   logic [1:0]   sync_a0;
   logic [1:0]   sync_a1;
   logic [1:0]   sync_b0;
   logic [1:0]   sync_b1;
   lin_state_t   lin_a_live;
   lin_state_t   lin_b_live;
   lin_state_t   lin_a_prev;
   lin_state_t   lin_b_prev;
   logic [7:0]   lin_mask;
   logic [3:0]   lin_flags;
   logic         meter_done_flag;
   logic         meter_done_irq_block;
   logic         meter_sel;
   logic [8:0]   result;
   meter_state_t meter_state;
   logic [15:0]  meter_count;
   logic         sel_write;
   logic         meter_finish;
   logic [3:0]   lin_events;
   logic         flags_write;
   logic [7:0]   next_rdata;

   assign sel_write   = req_valid && req.wr && req.addr == `METER_SEL_ADDR;
   assign flags_write = req_valid && req.wr && req.addr == `IRQ_FLAGS_ADDR;

   // Two-stage synchronisers for analog status pins
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         sync_a0 <= 2'h0;
         sync_b0 <= 2'h0;
         sync_a1 <= 2'h0;
         sync_b1 <= 2'h0;
      end else begin
         sync_a0 <= lin_a_pin;
         sync_b0 <= lin_b_pin;
         sync_a1 <= sync_a0;
         sync_b1 <= sync_b0;
      end
   end
   assign lin_a_live = sync_a1;
   assign lin_b_live = sync_b1;

   // Previous live state for edge detection
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         lin_a_prev <= 2'h0;
         lin_b_prev <= 2'h0;
      end else begin
         lin_a_prev <= lin_a_live;
         lin_b_prev <= lin_b_live;
      end
   end

   // Mask register, reserved bits held at zero
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         lin_mask <= `LIN_MASK_RESET;
      end else if (req_valid && req.wr && req.addr == `LIN_MASK_ADDR) begin
         lin_mask <= req.wdata & `LIN_MASK_WRITABLE;
      end
   end

   // Masked events: bit3 B power good, bit2 B overcurrent, bit1 A power good, bit0 A overcurrent
   always_comb begin
      lin_events[3] = (lin_b_prev.power_good && !lin_b_live.power_good && !lin_mask[`MASK_B_LOST])
                   || (!lin_b_prev.power_good && lin_b_live.power_good && !lin_mask[`MASK_B_REACH]);
      lin_events[2] = !lin_b_prev.overcurrent && lin_b_live.overcurrent && !lin_mask[`MASK_B_OC];
      lin_events[1] = (lin_a_prev.power_good && !lin_a_live.power_good && !lin_mask[`MASK_A_LOST])
                   || (!lin_a_prev.power_good && lin_a_live.power_good && !lin_mask[`MASK_A_REACH]);
      lin_events[0] = !lin_a_prev.overcurrent && lin_a_live.overcurrent && !lin_mask[`MASK_A_OC];
   end

   // Sticky flags, write one to clear, set wins
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         lin_flags       <= 4'h0;
         meter_done_flag <= 1'b0;
      end else begin
         lin_flags       <= (lin_flags & ~(flags_write ? req.wdata[3:0] : 4'h0)) | lin_events;
         meter_done_flag <= (meter_done_flag & !(flags_write && req.wdata[`FLAG_METER_DONE])) | meter_finish;
      end
   end

   // Ready interrupt mask
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         meter_done_irq_block <= 1'b0;
      end else if (req_valid && req.wr && req.addr == `METER_MASK_ADDR) begin
         meter_done_irq_block <= req.wdata[0];
      end
   end

   // Select register
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         meter_sel <= 1'b0;
      end else if (sel_write) begin
         meter_sel <= req.wdata[0];
      end
   end

   // Measurement sequencer; a write always restarts
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         meter_state <= METER_IDLE;
         meter_count <= 16'h0000;
      end else if (sel_write) begin
         meter_state <= METER_BUSY;
         meter_count <= 16'h0000;
      end else begin
         unique case (meter_state)
            METER_IDLE: begin
               meter_count <= 16'h0000;
            end
            METER_BUSY: begin
               if (meter_finish) begin
                  meter_state <= METER_IDLE;
               end
               meter_count <= meter_count + 16'h0001;
            end
         endcase
      end
   end
   assign meter_finish = meter_state == METER_BUSY && meter_count == 16'(METER_CYCLES - 1) && !sel_write;

   // Result captured whole on completion, 20 mA per count
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         result <= 9'h000;
      end else if (meter_finish) begin
         result <= meter_sample;
      end
   end

   // Read multiplexer
   always_comb begin
      unique case (req.addr)
         `LIN_MASK_ADDR:   next_rdata = lin_mask;
         `METER_SEL_ADDR:  next_rdata = {7'h00, meter_sel};
         `METER_HIGH_ADDR: next_rdata = {7'h00, result[8]};
         `METER_LOW_ADDR:  next_rdata = result[7:0];
         `IRQ_FLAGS_ADDR:  next_rdata = {3'h0, meter_done_flag, lin_flags};
         `LIVE_STATE_ADDR: next_rdata = {4'h0, lin_b_live, lin_a_live};
         `METER_MASK_ADDR: next_rdata = {7'h00, meter_done_irq_block};
         default:          next_rdata = 8'h00;
      endcase
   end

   // Read data registered on each read request, stands until the next read
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rdata <= 8'h00;
      end else if (req_valid && !req.wr) begin
         rdata <= next_rdata;
      end
   end

   assign meter_sel_b = meter_sel;
   assign meter_busy  = meter_state == METER_BUSY;
   assign irq         = (|lin_flags) || (meter_done_flag && !meter_done_irq_block);

   // Measurement steps
   sequence meter_restarted;
      meter_busy && meter_count == 16'h0000;
   endsequence
   sequence meter_recorded;
      meter_done_flag && !meter_busy;
   endsequence

   // Checks
   chk_mask_reserved_zero: assert property (@(posedge clk) disable iff (!rst_b)
      lin_mask[5] == 1'b0 && lin_mask[1] == 1'b0) else $error("reserved mask bit set");
   chk_b_lost_blocked: assert property (@(posedge clk) disable iff (!rst_b)
      lin_mask[`MASK_B_LOST] && lin_b_prev.power_good && !lin_b_live.power_good |-> !lin_events[3])
      else $error("masked B power good event");
   chk_b_reached_sets: assert property (@(posedge clk) disable iff (!rst_b)
      !lin_mask[`MASK_B_REACH] && !lin_b_prev.power_good && lin_b_live.power_good |=> lin_flags[3])
      else $error("B power good flag not set");
   chk_b_oc_sets: assert property (@(posedge clk) disable iff (!rst_b)
      !lin_mask[`MASK_B_OC] && !lin_b_prev.overcurrent && lin_b_live.overcurrent |=> lin_flags[2])
      else $error("B overcurrent flag not set");
   chk_a_lost_sets: assert property (@(posedge clk) disable iff (!rst_b)
      !lin_mask[`MASK_A_LOST] && lin_a_prev.power_good && !lin_a_live.power_good |=> lin_flags[1])
      else $error("A power good lost flag not set");
   chk_a_reached_block: assert property (@(posedge clk) disable iff (!rst_b)
      lin_mask[`MASK_A_REACH] && !lin_a_prev.power_good && lin_a_live.power_good |-> !lin_events[1])
      else $error("masked A reached event");
   chk_a_oc_block: assert property (@(posedge clk) disable iff (!rst_b)
      lin_mask[`MASK_A_OC] |-> !lin_events[0]) else $error("masked A overcurrent event");
   chk_live_tracks: assert property (@(posedge clk) disable iff (!rst_b)
      lin_a_live == $past(sync_a0) && lin_b_live == $past(sync_b0)) else $error("live state not tracking");
   chk_write_starts: assert property (@(posedge clk) disable iff (!rst_b)
      sel_write |=> meter_restarted ##0 meter_sel == $past(req.wdata[0]))
      else $error("select write did not start");
   chk_done_flag: assert property (@(posedge clk) disable iff (!rst_b)
      meter_finish |=> meter_recorded ##0 result == $past(meter_sample))
      else $error("completion not recorded");
   chk_result_held: assert property (@(posedge clk) disable iff (!rst_b)
      !meter_finish |=> $stable(result)) else $error("result changed without completion");
   chk_restart_no_result: assert property (@(posedge clk) disable iff (!rst_b)
      sel_write && meter_busy |=> $stable(result)) else $error("abandoned measurement stored a result");
endmodule
`default_nettype wire

// ==== pmu_regs_defs.svh ====
// Offsets, field positions, reset values and timing counts for the regulator register block
`ifndef PMU_REGS_DEFS_SVH
`define PMU_REGS_DEFS_SVH
`define LIN_MASK_ADDR       8'h23
`define METER_SEL_ADDR      8'h24
`define METER_HIGH_ADDR     8'h25
`define METER_LOW_ADDR      8'h26
`define IRQ_FLAGS_ADDR      8'h27
`define LIVE_STATE_ADDR     8'h28
`define METER_MASK_ADDR     8'h29
`define LIN_MASK_RESET      8'hCC
`define LIN_MASK_WRITABLE   8'hDD
`define MASK_B_LOST         7
`define MASK_B_REACH        6
`define MASK_B_OC           4
`define MASK_A_LOST         3
`define MASK_A_REACH        2
`define MASK_A_OC           0
`define FLAG_METER_DONE     4
`define METER_STEP_MA       20
`define METER_FULL_MA       10220
`define METER_TIME_US       100
`define CLK_MHZ             10
`define METER_CYCLES        (`METER_TIME_US * `CLK_MHZ)
`endif

// ==== pmu_regs_pkg.sv ====
// Types shared by the regulator register block
`default_nettype none
package pmu_regs_pkg;
   // One linear regulator's live conditions
   typedef struct packed {
      logic power_good;
      logic overcurrent;
   } lin_state_t;
   // Register access request
   typedef struct packed {
      logic       wr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } reg_req_t;
   typedef enum logic [0:0] {METER_IDLE, METER_BUSY} meter_state_t;
endpackage
`default_nettype wire

// ==== pmu_regs_bench.sv ====
// Self-checking bench for the regulator register block
`timescale 1ns/1ps
`include "pmu_regs_defs.svh"
`default_nettype none
module pmu_regs_bench;
   import pmu_regs_pkg::*;
   logic       clk = 1'b0;
   logic       rst_b = 1'b0;
   reg_req_t   req = '0;
   logic       req_valid = 1'b0;
   logic [7:0] rdata;
   lin_state_t lin_a_pin = '0;
   lin_state_t lin_b_pin = '0;
   logic [8:0] meter_sample = '0;
   logic       meter_sel_b;
   logic       meter_busy;
   logic       irq;
   int         n_fail = 0;
   int         n_compared = 0;
   int         cycles = 0;
   logic [7:0] d;
   // 100 ns clock
   always #50 clk = ~clk;
   pmu_regs uut (.clk(clk), .rst_b(rst_b), .req(req), .req_valid(req_valid), .rdata(rdata),
      .lin_a_pin(lin_a_pin), .lin_b_pin(lin_b_pin), .meter_sample(meter_sample),
      .meter_sel_b(meter_sel_b), .meter_busy(meter_busy), .irq(irq));
   // Comparisons
   task automatic check_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_compared++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic check_bit(input string what, input logic exp, input logic got);
      n_compared++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected %s: expected %b seen %b", what, exp, got);
      end
   endtask
   // Register accesses, one cycle each
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge clk);
      #1 req = '{1'b1, a, v};
      req_valid = 1'b1;
      @(posedge clk);
      #1 req_valid = 1'b0;
   endtask
   task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk);
      #1 req = '{1'b0, a, 8'h00};
      req_valid = 1'b1;
      @(posedge clk);
      #1 req_valid = 1'b0;
      d = rdata;
      check_byte(what, exp, d);
   endtask
   task automatic conclude;
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic test_reset;
      rd_chk("mask", `LIN_MASK_ADDR, `LIN_MASK_RESET);
      rd_chk("select", `METER_SEL_ADDR, 8'h00);
      rd_chk("result high", `METER_HIGH_ADDR, 8'h00);
      rd_chk("result low", `METER_LOW_ADDR, 8'h00);
      rd_chk("unmapped", 8'h3F, 8'h00);
      check_bit("busy", 1'b0, meter_busy);
      check_bit("irq", 1'b0, irq);
      $display("test reset done");
   endtask
   task automatic test_access;
      wr(`LIN_MASK_ADDR, 8'hFF);
      rd_chk("mask", `LIN_MASK_ADDR, `LIN_MASK_WRITABLE);
      wr(`METER_LOW_ADDR, 8'h5A);
      wr(`METER_HIGH_ADDR, 8'hFF);
      rd_chk("result low", `METER_LOW_ADDR, 8'h00);
      rd_chk("result high", `METER_HIGH_ADDR, 8'h00);
      $display("test access done");
   endtask
   // One event, first with only other bits masked, then with its own bit
   task automatic lin_case(input logic [7:0] m, input logic [1:0] ba, input logic [1:0] bb,
                           input logic [1:0] ea, input logic [1:0] eb, input logic [7:0] flag);
      for (int k = 0; k < 2; k++) begin
         lin_a_pin = ba;
         lin_b_pin = bb;
         repeat (6) @(posedge clk);
         #1 wr(`LIN_MASK_ADDR, (k == 1) ? m : (`LIN_MASK_WRITABLE & ~m));
         wr(`IRQ_FLAGS_ADDR, 8'hFF);
         lin_a_pin = ea;
         lin_b_pin = eb;
         repeat (6) @(posedge clk);
         rd_chk("linear flags", `IRQ_FLAGS_ADDR, (k == 1) ? 8'h00 : flag);
         check_bit("irq", (k == 0), irq);
         rd_chk("live state", `LIVE_STATE_ADDR, {4'h0, eb, ea});
      end
   endtask
   task automatic test_linear;
      lin_case(8'h01, 2'b00, 2'b00, 2'b01, 2'b00, 8'h01);
      lin_case(8'h04, 2'b00, 2'b00, 2'b10, 2'b00, 8'h02);
      lin_case(8'h08, 2'b10, 2'b00, 2'b00, 2'b00, 8'h02);
      lin_case(8'h10, 2'b00, 2'b00, 2'b00, 2'b01, 8'h04);
      lin_case(8'h40, 2'b00, 2'b00, 2'b00, 2'b10, 8'h08);
      lin_case(8'h80, 2'b00, 2'b10, 2'b00, 2'b00, 8'h08);
      wr(`IRQ_FLAGS_ADDR, 8'hFF);
      $display("test linear done");
   endtask
   // Bounded wait for the meter to finish, counting cycles
   task automatic wait_idle(output int n);
      n = 0;
      while (meter_busy === 1'b1 && n < 1100) begin
         @(posedge clk);
         #1 n++;
      end
   endtask
   task automatic test_meter;
      int n;
      meter_sample = 9'h1FF;
      wr(`METER_SEL_ADDR, 8'h01);
      check_bit("busy", 1'b1, meter_busy);
      check_bit("select out", 1'b1, meter_sel_b);
      rd_chk("select", `METER_SEL_ADDR, 8'h01);
      repeat (500) @(posedge clk);
      rd_chk("held low", `METER_LOW_ADDR, 8'h00);
      wr(`METER_SEL_ADDR, 8'h00);
      check_bit("select out", 1'b0, meter_sel_b);
      wait_idle(n);
      check_bit("restart length", 1'b1, n >= `METER_CYCLES - 2 && n <= `METER_CYCLES);
      rd_chk("result high", `METER_HIGH_ADDR, 8'h01);
      rd_chk("result low", `METER_LOW_ADDR, 8'hFF);
      rd_chk("done flag", `IRQ_FLAGS_ADDR, 8'h10);
      check_bit("irq", 1'b1, irq);
      wr(`METER_MASK_ADDR, 8'h01);
      check_bit("irq masked", 1'b0, irq);
      wr(`METER_MASK_ADDR, 8'h00);
      wr(`IRQ_FLAGS_ADDR, 8'hFF);
      meter_sample = 9'h0A5;
      wr(`METER_SEL_ADDR, 8'h01);
      wait_idle(n);
      rd_chk("result high", `METER_HIGH_ADDR, 8'h00);
      rd_chk("result low", `METER_LOW_ADDR, 8'hA5);
      $display("test meter done");
   endtask
   // Hang guard
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         n_fail++;
         conclude();
      end
   end
   initial begin
      repeat (10) @(posedge clk);
      #1 rst_b = 1'b1;
      test_reset();
      test_access();
      test_linear();
      test_meter();
      conclude();
   end
endmodule
`default_nettype wire
